// [nand_host_consts.vh]
// Constants for the NAND flash host controller: register map, fields, codes and timing
`ifndef NAND_HOST_CONSTS_VH
`define NAND_HOST_CONSTS_VH

// ****************************************
// Register byte offsets
// ****************************************
`define REG_CMD 5'h00
`define REG_ADDR 5'h04
`define REG_DATA 5'h08
`define REG_CTRL 5'h0C
`define REG_STATUS 5'h10

// ****************************************
// Field positions
// ****************************************
`define CMD_FIRST 7:0
`define CMD_SECOND 15:8
`define CMD_NADDR 17:16
`define CMD_CONFIRM 18
`define ADDR_COL 7:0
`define ADDR_ROW_LO 15:8
`define ADDR_ROW_HI 23:16
`define DATA_VALUE 15:0
`define DATA_READ 16
`define CTRL_X16 0
`define CTRL_HOLD_SEL 1
`define CTRL_WP_N 2
`define STATUS_SEQ_BUSY 0
`define STATUS_READY 1
`define STATUS_ERR 2
`define STATUS_RDATA 31:16

// ****************************************
// Reset values and bus answers
// ****************************************
`define CTRL_RESET 3'h4
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// ****************************************
// Flash command codes
// ****************************************
`define OP_READ_FIRST 8'h00
`define OP_READ_SECOND 8'h01
`define OP_READ_SPARE 8'h50
`define OP_READ_ID 8'h90
`define OP_RESET 8'hFF
`define OP_PROG_SETUP 8'h80
`define OP_PROG_EXEC 8'h10
`define OP_COPYBACK_EXEC 8'h8A
`define OP_LOCK 8'h2A
`define OP_UNLOCK_LO 8'h23
`define OP_UNLOCK_HI 8'h24
`define OP_LOCK_TIGHT 8'h2C
`define OP_LOCK_STATUS 8'h7A
`define OP_ERASE_SETUP 8'h60
`define OP_ERASE_EXEC 8'hD0
`define OP_STATUS 8'h70

// ****************************************
// Address cycle counts and steps
// ****************************************
`define NADDR_NONE 2'h0
`define NADDR_ONE 2'h1
`define NADDR_ROW 2'h2
`define NADDR_FULL 2'h3
`define STEP_CMD1 3'h0
`define STEP_COL 3'h1
`define STEP_ROW_LO 3'h2
`define STEP_ROW_HI 3'h3
`define STEP_CMD2 3'h4
`define STEP_DATA 3'h5
`define STEP_DONE 3'h7

// ****************************************
// Timing
// ****************************************
`define CLK_FREQ_MHZ 10
`define T_PHASE_NS 200
`define PHASE_CYC ((`T_PHASE_NS * `CLK_FREQ_MHZ + 999) / 1000)

`endif

// [strobe_timer.v]
// Phase divider: one-cycle tick every strobe phase while a sequence runs
`timescale 1ns/100ps
`include "nand_host_consts.vh"

module strobe_timer (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Control
  input wire run,
  output reg tick
);

  localparam integer PHASE_CYC = (`PHASE_CYC < 1) ? 1 : `PHASE_CYC;
  localparam [7:0] LAST = PHASE_CYC[7:0] - 8'h01;

  reg [7:0] count;

  // Restarting on every idle keeps the first phase full length
  always @(posedge aclk) begin
    if (!aresetn || !run) begin
      count <= 8'h00;
      tick <= 1'b0;
    end else if (count == LAST) begin
      count <= 8'h00;
      tick <= 1'b1;
    end else begin
      count <= count + 8'h01;
      tick <= 1'b0;
    end
  end

endmodule

// [nand_host_ctrl.v]
// NAND flash host controller with an AXI4-Lite register port
// Summary of operation
// - Address goes as column, low row, high row bytes, in that order.
// - Word-wide part: host holds upper eight I/O lines low in address cycles.
// - Values latch on rising write strobe, pulsed low with chip select low.
// - Command-latch high means command, address-latch high means address, else data.
// - Program, copy-back and erase: setup command, address cycles, execute command.
// - Read and program commands are followed by all three address cycles; host sends none, two or three as CMD_NADDR says, for any code.
// - Block erase sends only the two row cycles, no column.
// - While device busy only FFh and 70h may be sent.
// - Host never sends a command code outside the defined set.
`timescale 1ns/100ps
`include "nand_host_consts.vh"

module nand_host_ctrl (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write channels
  input wire [4:0] awaddr,
  input wire awvalid,
  output reg awready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output reg wready,
  output reg [1:0] bresp,
  output reg bvalid,
  input wire bready,
  // AXI4-Lite read channels
  input wire [4:0] araddr,
  input wire arvalid,
  output reg arready,
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  output reg rvalid,
  input wire rready,
  // Flash strobes
  output reg ce_n,
  output reg cle,
  output reg ale,
  output reg we_n,
  output reg read_strobe_n,
  output reg wp_n,
  // Flash I/O lines and ready/busy
  output reg [15:0] io_out,
  output reg io_oe,
  input wire [15:0] io_in,
  input wire ready_busy_n
);

  // ****************************************
  // Sequencer states
  // ****************************************
  localparam [5:0] ST_IDLE = 6'h01;
  localparam [5:0] ST_SETUP = 6'h02;
  localparam [5:0] ST_WLOW = 6'h04;
  localparam [5:0] ST_WHOLD = 6'h08;
  localparam [5:0] ST_RLOW = 6'h10;
  localparam [5:0] ST_RHOLD = 6'h20;

  reg [5:0] state;
  reg [2:0] step;
  reg [31:0] cmd_reg;
  reg [23:0] addr_reg;
  reg [15:0] wr_data;
  reg [15:0] rd_data;
  reg [2:0] ctrl_reg;
  reg err;
  wire tick;

  // ****************************************
  // Helpers
  // ****************************************
  // defined set
  function defined_op;
    input [7:0] op;
    input x16;
    begin
      case (op)
        `OP_READ_FIRST, `OP_READ_SPARE, `OP_READ_ID, `OP_RESET, `OP_PROG_SETUP, `OP_PROG_EXEC,
        `OP_COPYBACK_EXEC, `OP_LOCK, `OP_UNLOCK_LO, `OP_UNLOCK_HI, `OP_LOCK_TIGHT,
        `OP_LOCK_STATUS, `OP_ERASE_SETUP, `OP_ERASE_EXEC, `OP_STATUS: defined_op = 1'b1;
        `OP_READ_SECOND: defined_op = !x16;
        default: defined_op = 1'b0;
      endcase
    end
  endfunction

  // address order, row only, execute last
  function [2:0] after_step;
    input [2:0] s;
    input [1:0] naddr;
    input confirm;
    begin
      case (s)
        `STEP_CMD1: begin
          if (naddr == `NADDR_FULL) begin
            after_step = `STEP_COL;
          end else if (naddr == `NADDR_ROW) begin
            after_step = `STEP_ROW_LO;
          end else begin
            after_step = confirm ? `STEP_CMD2 : `STEP_DONE;
          end
        end
        `STEP_COL: after_step = `STEP_ROW_LO;
        `STEP_ROW_LO: after_step = `STEP_ROW_HI;
        `STEP_ROW_HI: after_step = confirm ? `STEP_CMD2 : `STEP_DONE;
        default: after_step = `STEP_DONE;
      endcase
    end
  endfunction

  function [31:0] merge;
    input [31:0] old;
    input [31:0] din;
    input [3:0] strb;
    integer i;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        merge[8*i +: 8] = strb[i] ? din[8*i +: 8] : old[8*i +: 8];
      end
    end
  endfunction

  // ****************************************
  // Launch decode
  // ****************************************
  wire wr_fire = awready;
  wire idle = (state == ST_IDLE);
  wire x16 = ctrl_reg[`CTRL_X16];
  wire [7:0] new_cmd1 = wdata[`CMD_FIRST];
  wire [1:0] new_naddr = wdata[`CMD_NADDR];
  wire new_conf = wdata[`CMD_CONFIRM];
  wire busy_ok = (new_cmd1 == `OP_RESET) || (new_cmd1 == `OP_STATUS);
  wire cmd_hit = wr_fire && (awaddr == `REG_CMD);
  wire data_hit = wr_fire && (awaddr == `REG_DATA);
  // only reset and status while busy, single cycle
  wire cmd_legal = idle && defined_op(new_cmd1, x16) && (!new_conf || defined_op(wdata[`CMD_SECOND], x16)) &&
                   (new_naddr != `NADDR_ONE) && (ready_busy_n || (busy_ok && !new_conf && new_naddr == `NADDR_NONE));
  wire data_legal = idle && ready_busy_n;
  wire launch_cmd = cmd_hit && cmd_legal;
  wire launch_data = data_hit && data_legal;
  wire refused = (cmd_hit && !cmd_legal) || (data_hit && !data_legal);
  wire mapped_w = (awaddr == `REG_CMD) || (awaddr == `REG_ADDR) || (awaddr == `REG_DATA) ||
                  (awaddr == `REG_CTRL) || (awaddr == `REG_STATUS);

  wire [2:0] next_step = after_step(step, cmd_reg[`CMD_NADDR], cmd_reg[`CMD_CONFIRM]);

  // ****************************************
  // Value presented for the next step
  // ****************************************
  // Keyed on the next step so the byte is on the lines a full phase before the strobe falls
  reg [15:0] step_io;
  always @* begin
    case (next_step)
      `STEP_CMD1: step_io = {8'h00, cmd_reg[`CMD_FIRST]};
      `STEP_COL: step_io = {8'h00, addr_reg[`ADDR_COL]};
      `STEP_ROW_LO: step_io = {8'h00, addr_reg[`ADDR_ROW_LO]};
      `STEP_ROW_HI: step_io = {8'h00, addr_reg[`ADDR_ROW_HI]};
      `STEP_CMD2: step_io = {8'h00, cmd_reg[`CMD_SECOND]};
      `STEP_DATA: step_io = x16 ? wr_data : {8'h00, wr_data[7:0]};
      default: step_io = 16'h0000;
    endcase
  end

  wire [31:0] addr_merged = merge({8'h00, addr_reg}, wdata, wstrb);

  strobe_timer u_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(!idle),
    .tick(tick)
  );

  // ****************************************
  // AXI4-Lite slave
  // ****************************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rresp <= `RESP_OKAY;
      rdata <= 32'h00000000;
      cmd_reg <= 32'h00000000;
      addr_reg <= 24'h000000;
      wr_data <= 16'h0000;
      ctrl_reg <= `CTRL_RESET;
      err <= 1'b0;
    end else begin
      awready <= awvalid && wvalid && !awready && !bvalid;
      wready <= awvalid && wvalid && !awready && !bvalid;
      if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
      if (wr_fire) begin
        bvalid <= 1'b1;
        bresp <= (mapped_w && !refused) ? `RESP_OKAY : `RESP_SLVERR;
        if (awaddr == `REG_ADDR) begin
          addr_reg <= addr_merged[23:0];
        end
        if (awaddr == `REG_CTRL) begin
          ctrl_reg <= wstrb[0] ? wdata[2:0] : ctrl_reg;
        end
      end
      if (launch_cmd) begin
        cmd_reg <= wdata;
      end
      if (launch_data) begin
        wr_data <= wdata[`DATA_VALUE];
      end
      // Error flag: a refusal in the clearing cycle still sets it
      if (refused) begin
        err <= 1'b1;
      end else if (wr_fire && awaddr == `REG_STATUS && wdata[`STATUS_ERR]) begin
        err <= 1'b0;
      end
      arready <= arvalid && !arready && !rvalid;
      if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
      if (arready) begin
        rvalid <= 1'b1;
        rresp <= `RESP_OKAY;
        case (araddr)
          `REG_CMD: rdata <= cmd_reg;
          `REG_ADDR: rdata <= {8'h00, addr_reg};
          `REG_DATA: rdata <= {16'h0000, rd_data};
          `REG_CTRL: rdata <= {29'h0000000, ctrl_reg};
          `REG_STATUS: rdata <= {rd_data, 13'h0000, err, ready_busy_n, !idle};
          default: begin
            rdata <= 32'h00000000;
            rresp <= `RESP_SLVERR;
          end
        endcase
      end
    end
  end

  // ****************************************
  // Strobe sequencer
  // ****************************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_IDLE;
      step <= `STEP_DONE;
      rd_data <= 16'h0000;
      ce_n <= 1'b1;
      cle <= 1'b0;
      ale <= 1'b0;
      we_n <= 1'b1;
      read_strobe_n <= 1'b1;
      wp_n <= 1'b1;
      io_out <= 16'h0000;
      io_oe <= 1'b0;
    end else begin
      wp_n <= ctrl_reg[`CTRL_WP_N];
      case (state)
        ST_IDLE: begin
          // Holding select low lets a read stream survive between single-word reads
          ce_n <= !ctrl_reg[`CTRL_HOLD_SEL];
          cle <= 1'b0;
          ale <= 1'b0;
          io_oe <= 1'b0;
          if (launch_cmd) begin
            state <= ST_SETUP;
            step <= `STEP_CMD1;
            ce_n <= 1'b0;
            cle <= 1'b1;
            io_out <= {8'h00, new_cmd1};
            io_oe <= 1'b1;
          end else if (launch_data) begin
            state <= ST_SETUP;
            step <= wdata[`DATA_READ] ? `STEP_DONE : `STEP_DATA;
            ce_n <= 1'b0;
            io_out <= x16 ? wdata[`DATA_VALUE] : {8'h00, wdata[7:0]};
            io_oe <= !wdata[`DATA_READ];
          end
        end
        ST_SETUP: begin
          if (tick) begin
            // strobe low with chip select low
            if (step == `STEP_DONE) begin
              read_strobe_n <= 1'b0;
              state <= ST_RLOW;
            end else begin
              we_n <= 1'b0;
              state <= ST_WLOW;
            end
          end
        end
        ST_WLOW: begin
          if (tick) begin
            // device latches on this rising edge
            we_n <= 1'b1;
            state <= ST_WHOLD;
          end
        end
        ST_WHOLD: begin
          if (tick) begin
            if (step != `STEP_DATA && next_step != `STEP_DONE) begin
              // upper lines low, latch selects, address cycles
              step <= next_step;
              cle <= (next_step == `STEP_CMD2);
              ale <= (next_step != `STEP_CMD2);
              io_out <= step_io;
              state <= ST_SETUP;
            end else begin
              state <= ST_IDLE;
              io_oe <= 1'b0;
              cle <= 1'b0;
              ale <= 1'b0;
            end
          end
        end
        ST_RLOW: begin
          if (tick) begin
            // word presented after the falling edge, sampled before rising
            rd_data <= x16 ? io_in : {8'h00, io_in[7:0]};
            read_strobe_n <= 1'b1;
            state <= ST_RHOLD;
          end
        end
        ST_RHOLD: begin
          if (tick) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

// [nand_host_ctrl_asserts.sv]
// Port checker for the NAND host controller
`timescale 1ns/100ps
module nand_host_ctrl_asserts (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Bus handshakes
  input wire awready,
  input wire wready,
  input wire bvalid,
  input wire arready,
  input wire rvalid,
  // Flash pins
  input wire ce_n,
  input wire cle,
  input wire ale,
  input wire we_n,
  input wire read_strobe_n,
  input wire io_oe,
  input wire [15:0] io_out,
  input wire ready_busy_n
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_we_selected: assert property (!we_n |-> !ce_n)
    else $error("write strobe without chip select");
  a_we_pulse: assert property ($fell(we_n) |=> !we_n ##1 we_n)
    else $error("write strobe low phase length");
  a_io_held: assert property (!we_n |=> $stable(io_out) && $stable(cle) && $stable(ale))
    else $error("lines moved under write strobe");
  a_latch_excl: assert property (!(cle && ale))
    else $error("command and address latch together");
  a_upper_low: assert property (io_oe && (cle || ale) |-> io_out[15:8] == 8'h00)
    else $error("upper lines not low");
  // Any code outside the set can put the part in an unknown mode
  a_code_defined: assert property (cle && !we_n |-> io_out[7:0] inside {8'h00, 8'h01, 8'h50, 8'h90, 8'hFF,
    8'h80, 8'h10, 8'h8A, 8'h2A, 8'h23, 8'h24, 8'h2C, 8'h7A, 8'h60, 8'hD0, 8'h70}) else $error("undefined code");
  a_busy_codes: assert property ($rose(cle) && $past(awready) && !$past(ready_busy_n)
    |-> io_out[7:0] == 8'hFF || io_out[7:0] == 8'h70) else $error("code sent while busy");
  a_read_released: assert property (!read_strobe_n |-> !io_oe && we_n && !ce_n)
    else $error("read strobe with host driving");
  a_resp_timing: assert property (awready |-> wready ##1 bvalid)
    else $error("write answer late");
  a_rdata_timing: assert property (arready |=> rvalid)
    else $error("read answer late");
endmodule
bind nand_host_ctrl nand_host_ctrl_asserts u_chk (
  .aclk, .aresetn, .awready, .wready, .bvalid, .arready, .rvalid,
  .ce_n, .cle, .ale, .we_n, .read_strobe_n, .io_oe, .io_out, .ready_busy_n
);

// [flash_model.sv]
// Behavioural flash device on the far side of the host pins
`timescale 1ns/100ps
module flash_model #(
  parameter BUSY_CYC = 40
) (
  // Clock
  input wire aclk,
  // Strobes
  input wire ce_n,
  input wire cle,
  input wire ale,
  input wire we_n,
  input wire read_strobe_n,
  // I/O lines and ready/busy
  input wire io_oe,
  input wire [15:0] io_out,
  output reg [15:0] io_in = 16'h0000,
  output wire ready_busy_n
);
  reg [17:0] lg [0:63];
  integer n = 0;
  integer bcnt = 0;
  reg viol = 1'b0;
  reg p_we = 1'b1;
  reg p_re = 1'b1;
  reg half = 1'b0;
  reg [1:0] acyc = 2'h0;
  reg [15:0] col = 16'h0000;
  reg ers = 1'b0;
  reg spare = 1'b0;
  // 65,536 pages need sixteen row bits
  reg [15:0] row = 16'h0000;
  reg [10:0] blk = 11'h000;
  // busy low while working, chip select ignored
  assign ready_busy_n = (bcnt == 0);
  always @(posedge aclk) begin
    p_we <= we_n;
    p_re <= read_strobe_n;
    if (bcnt != 0) bcnt <= bcnt - 1;
    // latch on rising strobe, kind from latch lines
    if (we_n && !p_we && !ce_n) begin
      lg[n] <= {cle ? 2'h1 : ale ? 2'h2 : 2'h3, io_out};
      n <= n + 1;
      if (cle) begin
        acyc <= 2'h0;
        // only reset and status while busy
        if (bcnt != 0 && io_out[7:0] != 8'hFF && io_out[7:0] != 8'h70) viol <= 1'b1;
        // read code picks the page half
        if (io_out[7:0] == 8'h00 || io_out[7:0] == 8'h01) half <= io_out[0];
        if (io_out[7:0] == 8'h10 || io_out[7:0] == 8'h8A || io_out[7:0] == 8'hD0) bcnt <= BUSY_CYC;
        if (io_out[7:0] == 8'hFF) bcnt <= 0;
        ers <= (io_out[7:0] == 8'h60);
        // spare read starts at column 512, main reads leave the spare area
        if (io_out[7:0] == 8'h50) spare <= 1'b1;
        if (io_out[7:0] == 8'h00 || io_out[7:0] == 8'h01) spare <= 1'b0;
        // erase takes the block from row bits 15:5, page bits 4:0 ignored
        if (io_out[7:0] == 8'hD0) blk <= row[15:5];
      end else if (ale) begin
        // upper lines low in address cycles
        if (io_out[15:8] != 8'h00) viol <= 1'b1;
        // first cycle is the column (none for erase), surplus ignored
        if (acyc == 2'h0 && !ers) col <= spare ? {12'h020, io_out[3:0]} : {7'h00, half, io_out[7:0]};
        if ({1'b0, acyc} + {2'h0, ers} == 3'h1) row[7:0] <= io_out[7:0];
        if ({1'b0, acyc} + {2'h0, ers} == 3'h2) row[15:8] <= io_out[7:0];
        if (acyc != 2'h3) acyc <= acyc + 2'h1;
      end
    end
    // falling read strobe drives next word, column advances
    if (io_oe) io_in <= io_out;
    else if (!read_strobe_n && p_re) begin
      io_in <= {col[7:0] ^ 8'hA5, col[7:0] ^ (col[9] ? 8'h5A : col[8] ? 8'h3C : 8'hC3)};
      col <= col + 16'h0001;
    end else if (read_strobe_n) io_in <= ~io_in;
  end
endmodule

// [nand_host_ctrl_tb.sv]
// Self-checking bench: host controller driving the flash model
`timescale 1ns/100ps
`include "nand_host_consts.vh"
`define CHK(g, e) begin compares = compares + 1; if ((g) !== (e)) begin \
  $display("ERROR %0t: got %h expected %h", $time, g, e); bad_count = bad_count + 1; end end
module nand_host_ctrl_tb;
  reg aclk = 1'b0;
  reg aresetn = 1'b0;
  reg [4:0] awaddr = 5'h00;
  reg awvalid = 1'b0;
  reg [31:0] wdata = 32'h0;
  reg [3:0] wstrb = 4'hF;
  reg wvalid = 1'b0;
  reg bready = 1'b0;
  reg [4:0] araddr = 5'h00;
  reg arvalid = 1'b0;
  reg rready = 1'b0;
  wire awready, wready, bvalid, arready, rvalid, ce_n, cle, ale, we_n, read_strobe_n, wp_n, io_oe, ready_busy_n;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [15:0] io_out, io_in;
  reg [31:0] rv;
  reg [1:0] rr;
  reg [63:0] codes = 64'h0150902A2C7AFF00;
  integer bad_count = 0;
  integer compares = 0;
  integer b = 0;
  integer i;
  always #50 aclk = ~aclk;
  nand_host_ctrl u_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .ce_n, .cle, .ale,
    .we_n, .read_strobe_n, .wp_n, .io_out, .io_oe, .io_in, .ready_busy_n);
  // Long busy so a refusal can be tried before the part recovers
  flash_model #(.BUSY_CYC(100)) u_flash (.aclk, .ce_n, .cle, .ale, .we_n, .read_strobe_n, .io_oe, .io_out,
    .io_in, .ready_busy_n);
  // ****************************************
  // Bus tasks
  // ****************************************
  task wr(input [4:0] a, input [31:0] d, input [1:0] er);
    begin
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      @(posedge aclk);
      while (bvalid !== 1'b1) begin
        if (awready === 1'b1) awvalid <= 1'b0;
        if (wready === 1'b1) wvalid <= 1'b0;
        @(posedge aclk);
      end
      `CHK(bresp, er)
      bready <= 1'b0;
      @(posedge aclk);
    end
  endtask
  task rd(input [4:0] a);
    begin
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      @(posedge aclk);
      while (rvalid !== 1'b1) begin
        if (arready === 1'b1) arvalid <= 1'b0;
        @(posedge aclk);
      end
      rv = rdata;
      rr = rresp;
      rready <= 1'b0;
      @(posedge aclk);
    end
  endtask
  task wst(input integer k, input v);
    begin
      rd(`REG_STATUS);
      while (rv[k] !== v) rd(`REG_STATUS);
    end
  endtask
  task lgs(input integer k, input [89:0] v);
    integer j;
    begin
      for (j = 0; j < k; j = j + 1)
        `CHK(u_flash.lg[b + j], v[89 - 18 * j -: 18])
      b = b + k;
    end
  endtask
  task conclude;
    begin
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  initial begin
    repeat (30000) @(posedge aclk);
    bad_count = bad_count + 1;
    conclude;
  end
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`REG_CTRL);
    `CHK(rv, 32'h00000004)
    rd(5'h14);
    `CHK(rr, `RESP_SLVERR)
    wr(5'h18, 32'h0, `RESP_SLVERR);
    wr(`REG_ADDR, 32'h00563412, `RESP_OKAY);
    wr(`REG_CMD, 32'h00071080, `RESP_OKAY);
    wst(0, 1'b0);
    lgs(5, {18'h10080, 18'h20012, 18'h20034, 18'h20056, 18'h10010});
    wr(`REG_CMD, 32'h00000090, `RESP_SLVERR);
    wr(`REG_CMD, 32'h00000070, `RESP_OKAY);
    wst(0, 1'b0);
    `CHK(rv[2:1], 2'b10)
    lgs(1, {18'h10070, 72'h0});
    wr(`REG_STATUS, 32'h4, `RESP_OKAY);
    wst(1, 1'b1);
    wr(`REG_CMD, 32'h0006D060, `RESP_OKAY);
    wst(0, 1'b0);
    lgs(4, {18'h10060, 18'h20034, 18'h20056, 18'h100D0, 18'h0});
    `CHK(u_flash.blk, 11'h2B1)
    wst(1, 1'b1);
    wr(`REG_CMD, 32'h00078A00, `RESP_OKAY);
    wst(0, 1'b0);
    lgs(5, {18'h10000, 18'h20012, 18'h20034, 18'h20056, 18'h1008A});
    wst(1, 1'b1);
    wr(`REG_CMD, 32'h00000033, `RESP_SLVERR);
    wr(`REG_CMD, 32'h00010000, `RESP_SLVERR);
    for (i = 0; i < 8; i = i + 1) begin
      wr(`REG_CMD, {24'h0, codes[63 - 8 * i -: 8]}, `RESP_OKAY);
      wst(0, 1'b0);
      lgs(1, {10'h100, codes[63 - 8 * i -: 8], 72'h0});
    end
    wr(`REG_CMD, 32'h00042423, `RESP_OKAY);
    wst(0, 1'b0);
    lgs(2, {18'h10023, 18'h10024, 54'h0});
    wr(`REG_CTRL, 32'h1, `RESP_OKAY);
    `CHK(wp_n, 1'b0)
    wr(`REG_CMD, 32'h1, `RESP_SLVERR);
    wr(`REG_ADDR, 32'h40, `RESP_OKAY);
    wr(`REG_CMD, 32'h00030000, `RESP_OKAY);
    wst(0, 1'b0);
    wr(`REG_DATA, 32'h0000BEEF, `RESP_OKAY);
    wst(0, 1'b0);
    lgs(5, {18'h10000, 18'h20040, 18'h20000, 18'h20000, 18'h3BEEF});
    for (i = 0; i < 2; i = i + 1) begin
      wr(`REG_DATA, 32'h00010000, `RESP_OKAY);
      wst(0, 1'b0);
      `CHK(rv[31:16], (i == 0) ? 16'hE583 : 16'hE482)
    end
    wr(`REG_CTRL, 32'h4, `RESP_OKAY);
    wr(`REG_CMD, 32'h00030001, `RESP_OKAY);
    wst(0, 1'b0);
    lgs(4, {18'h10001, 18'h20040, 18'h20000, 18'h20000, 18'h0});
    wr(`REG_DATA, 32'h00010000, `RESP_OKAY);
    wst(0, 1'b0);
    `CHK(rv[23:16], 8'h7C)
    wr(`REG_ADDR, 32'h00000003, `RESP_OKAY);
    wr(`REG_CMD, 32'h00030050, `RESP_OKAY);
    wst(0, 1'b0);
    lgs(4, {18'h10050, 18'h20003, 18'h20000, 18'h20000, 18'h0});
    wr(`REG_DATA, 32'h00010000, `RESP_OKAY);
    wst(0, 1'b0);
    `CHK(rv[31:16], 16'h0059)
    wstrb <= 4'h2;
    wr(`REG_ADDR, 32'h00AABB00, `RESP_OKAY);
    wstrb <= 4'hF;
    rd(`REG_ADDR);
    `CHK(rv, 32'h0000BB03)
    `CHK(u_flash.viol, 1'b0)
    `CHK(u_flash.n, b)
    conclude;
  end
endmodule
